// >>> src/rcb_pkg.sv
// shared constants and types of the reset, clock and boot control block
package rcb_pkg;
    // register byte offsets on the apb slave
    localparam logic [7:0] OFF_CLK_CTRL  = 8'h00;
    localparam logic [7:0] OFF_CLK_DIV   = 8'h04;
    localparam logic [7:0] OFF_STATUS    = 8'h08;
    localparam logic [7:0] OFF_POWER     = 8'h0c;
    localparam logic [7:0] OFF_SUPPLY    = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h18;
    localparam logic [7:0] OFF_IRQ_CLR   = 8'h1c;
    localparam logic [7:0] OFF_RST_CAUSE = 8'h20;

    // system clock sources
    typedef enum logic [1:0] {
        SRC_FAST_INT  = 2'h0,
        SRC_EXT_FAST  = 2'h1,
        SRC_PLL       = 2'h2,
        SRC_SLOW_INT  = 2'h3
    } sys_src_t;

    // boot areas
    localparam logic [1:0] BOOT_MAIN_FLASH = 2'h0;
    localparam logic [1:0] BOOT_SYSTEM_MEM = 2'h1;
    localparam logic [1:0] BOOT_SRAM       = 2'h2;

    // fast oscillator frequency codes
    localparam logic [2:0] FREQ_4M    = 3'h0;
    localparam logic [2:0] FREQ_8M    = 3'h1;
    localparam logic [2:0] FREQ_16M   = 3'h2;
    localparam logic [2:0] FREQ_22M12 = 3'h3;
    localparam logic [2:0] FREQ_24M   = 3'h4;

    // clock control register layout, msb first
    typedef struct packed {
        logic       slow_ext_en;
        logic       slow_int_en;
        sys_src_t   sys_src;
        logic       css_en;
        logic       pll_src_ext;
        logic       pll_en;
        logic       ext_fast_en;
        logic [2:0] fast_freq;
    } clk_ctrl_t;
    localparam clk_ctrl_t CLK_CTRL_RST = '{1'b0, 1'b0, SRC_FAST_INT,
        1'b0, 1'b0, 1'b0, 1'b0, FREQ_8M};

    // bus divider shifts: ahb = sys >> ahb, apb = ahb >> apb
    typedef struct packed {
        logic [2:0] apb_shift;
        logic [2:0] ahb_shift;
    } clk_div_t;
    localparam clk_div_t CLK_DIV_RST = '{3'h0, 3'h0};
    localparam logic [2:0] APB_SHIFT_MAX = 3'h4;

    // low power control register layout
    typedef struct packed {
        logic [7:0] keep_mask;
        logic       stop_lp_reg;
        logic       stop_req;
        logic       sleep_req;
    } power_t;
    localparam power_t POWER_RST = '{8'h00, 1'b0, 1'b0, 1'b0};

    // supply level detector setup
    typedef struct packed {
        logic       pin_sel;
        logic [2:0] level;
        logic       enable;
    } supply_t;
    localparam supply_t SUPPLY_RST = '{1'b0, 3'h0, 1'b0};

    // sticky events, same layout for status, enable and clear
    typedef struct packed {
        logic stop_wake;
        logic supply_fall;
        logic supply_rise;
        logic css_fail;
    } events_t;

    // reset cause flags
    typedef struct packed {
        logic power;
        logic opt_load;
        logic soft_req;
        logic ind_wdog;
        logic win_wdog;
        logic pin;
    } rst_cause_t;

    // clock rates and timing
    localparam int unsigned CLK_MHZ         = 200;
    localparam int unsigned SWITCH_GAP_NS   = 20;
    localparam int unsigned SWITCH_GAP_CYC  =
        (SWITCH_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [19:0] BUS_MAX_KHZ     = 20'd48000;
    localparam logic [19:0] SLOW_KHZ        = 20'd33;

    // fast oscillator rate in khz per frequency code
    function automatic logic [19:0] fast_khz(input logic [2:0] code);
        case (code)
            FREQ_4M:    fast_khz = 20'd4000;
            FREQ_16M:   fast_khz = 20'd16000;
            FREQ_22M12: fast_khz = 20'd22120;
            FREQ_24M:   fast_khz = 20'd24000;
            default:    fast_khz = 20'd8000;
        endcase
    endfunction
endpackage

// >>> src/clk_switch_seq.sv
// break-before-make sequencer for the system clock source gates
`timescale 1ns/1ps
module clk_switch_seq (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    // requested source and per-source readiness
    input  rcb_pkg::sys_src_t       i_req_src,
    input  wire logic [3:0]         i_ready,
    // gates and the source now running
    output logic [3:0]              o_gate,
    output rcb_pkg::sys_src_t       o_cur_src
);
    typedef enum logic [1:0] {
        ST_RUN,
        ST_DROP,
        ST_WAIT
    } sw_state_t;

    sw_state_t          state_q;       // sequencer state
    rcb_pkg::sys_src_t  cur_q;         // source in use
    rcb_pkg::sys_src_t  tgt_q;         // source being switched to
    logic [3:0]         gate_q;        // one-hot gate, registered
    logic [7:0]         gap_q;         // quiet-time counter

    // all gates are closed for the gap, so no short pulse can pass
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= ST_RUN;
            cur_q   <= rcb_pkg::SRC_FAST_INT;
            tgt_q   <= rcb_pkg::SRC_FAST_INT;
            gate_q  <= 4'h1;
            gap_q   <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_RUN:
                    // a new source is taken only once it is ready
                    if (i_req_src != cur_q && i_ready[i_req_src])
                    begin
                        tgt_q   <= i_req_src;
                        gate_q  <= 4'h0;
                        state_q <= ST_DROP;
                    end
                ST_DROP:
                begin
                    gap_q   <= 8'(rcb_pkg::SWITCH_GAP_CYC);
                    state_q <= ST_WAIT;
                end
                ST_WAIT:
                    if (gap_q > 8'h01)
                        gap_q <= gap_q - 8'h01;
                    else
                    begin
                        cur_q           <= tgt_q;
                        gate_q          <= 4'h0;
                        gate_q[tgt_q]   <= 1'b1;
                        state_q         <= ST_RUN;
                    end
                default:
                    state_q <= ST_RUN;
            endcase
        end
    end

    assign o_gate    = gate_q;
    assign o_cur_src = cur_q;
endmodule

// >>> src/rst_clk_boot_ctrl.sv
// reset, clock, boot and low power control with an apb register file
//
// What this block does
// - boot pin low means main flash
// - reset runs system clock from 8 MHz oscillator
// - fast oscillator selectable 4/8/16/22.12/24 MHz
// - monitor failure switches to fast oscillator
// - monitor failure raises non-maskable interrupt too
// - pll input is fast oscillator or crystal
// - failure with crystal pll stops pll, crystal
// - divided bus clocks never exceed 48 MHz
// - two slow clocks at 32.768 kHz
// - sleep stops cpu, kept peripherals run
// - stop turns off fast clocks, keeps state
// - stop exits on any listed wake event
// - power reset from por/pdr or brownout
// - system reset from six listed sources
// - por/pdr monitor active in every mode
// - brownout setup only from option storage
// - supply detector flags crossings, feeds line 16
// - stop regulator chosen by software bit
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module rst_clk_boot_ctrl #(
    parameter logic [19:0] EXT_FAST_KHZ = 20'd8000  // crystal rate
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // boot straps
    input  wire logic        i_boot_select_pin,
    input  wire logic        i_boot_option_bit,
    output logic [1:0]       o_boot_area,
    // oscillator control and status
    input  wire logic        i_fast_rdy,
    input  wire logic        i_ext_fast_rdy,
    input  wire logic        i_pll_lock,
    input  wire logic        i_slow_int_rdy,
    input  wire logic        i_ext_fast_fail,
    output logic             o_fast_osc_en,
    output logic [2:0]       o_fast_osc_freq,
    output logic             o_ext_fast_en,
    output logic             o_pll_en,
    output logic             o_pll_src_ext,
    output logic             o_slow_int_en,
    output logic             o_slow_ext_en,
    // clock gates and dividers
    output logic [3:0]       o_sys_gate,
    output logic [2:0]       o_ahb_shift,
    output logic [2:0]       o_apb_shift,
    output logic             o_cpu_clk_en,
    output logic [7:0]       o_periph_clk_en,
    output logic             o_stop_lp_reg,
    // wake and interrupts
    input  wire logic [4:0]  i_wake,
    output logic             o_irq,
    output logic             o_nmi,
    // supply monitors and options
    input  wire logic        i_por_low,
    input  wire logic        i_bor_low,
    input  wire logic        i_supply_above,
    input  wire logic        i_opt_bor_en,
    input  wire logic [2:0]  i_opt_bor_rise,
    input  wire logic [2:0]  i_opt_bor_fall,
    output logic             o_bor_en,
    output logic [2:0]       o_bor_rise_thr,
    output logic [2:0]       o_bor_fall_thr,
    output logic [2:0]       o_supply_level,
    output logic             o_supply_pin_sel,
    output logic             o_supply_event,
    // reset sources and results
    input  wire logic        i_ext_reset_pin,
    input  wire logic        i_win_wdog_exp,
    input  wire logic        i_ind_wdog_exp,
    input  wire logic        i_soft_reset_req,
    input  wire logic        i_opt_load_reset,
    output logic             o_power_reset,
    output logic             o_system_reset
);
    rcb_pkg::clk_ctrl_t  ctrl_q;      // clock control register
    rcb_pkg::clk_div_t   div_q;       // programmed divider shifts
    rcb_pkg::power_t     pwr_q;       // low power control
    rcb_pkg::supply_t    sup_q;       // supply detector setup
    rcb_pkg::events_t    ev_q;        // sticky event status
    rcb_pkg::events_t    ev_en_q;     // event enables
    rcb_pkg::events_t    ev_set;      // events this cycle
    rcb_pkg::rst_cause_t cause_q;     // reset cause flags
    rcb_pkg::rst_cause_t cause_set;   // reset sources now
    rcb_pkg::sys_src_t   cur_src;     // source the switch runs
    logic        boot_done_q;         // straps caught
    logic [1:0]  boot_q;              // latched boot area
    logic        stop_q;              // in stop mode
    logic        sleep_q;             // in sleep mode
    logic        sup_q_out;           // registered detector output
    logic        css_fire;            // monitor failure this cycle
    logic        wr;                  // apb write strobe
    logic        setup;               // apb setup cycle
    logic        mapped;              // address hits a register
    logic [31:0] rd_mux;              // read data before the flop
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [19:0] sys_khz;             // rate of the running source
    logic [2:0]  ahb_eff;             // divider shift actually used
    logic        pwr_rst_q;
    logic        sys_rst_q;
    logic [3:0]  src_rdy;             // readiness per source

    assign wr    = psel && penable && pwrite;
    assign setup = psel && !penable;

    // monitor trips only while crystal feeds the system directly or via pll
    assign css_fire = ctrl_q.css_en && i_ext_fast_fail && ctrl_q.ext_fast_en
        && (cur_src == rcb_pkg::SRC_EXT_FAST
            || (cur_src == rcb_pkg::SRC_PLL && ctrl_q.pll_src_ext));

    // straps are caught once after reset release, never under reset
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            boot_done_q <= 1'b0;
            boot_q      <= rcb_pkg::BOOT_MAIN_FLASH;
        end
        else if (!boot_done_q)
        begin
            boot_done_q <= 1'b1;
            if (!i_boot_select_pin)
                boot_q <= rcb_pkg::BOOT_MAIN_FLASH;
            else if (i_boot_option_bit)
                boot_q <= rcb_pkg::BOOT_SYSTEM_MEM;
            else
                boot_q <= rcb_pkg::BOOT_SRAM;
        end
    end

    // clock control register, with hardware fallback on monitor failure
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ctrl_q <= rcb_pkg::CLK_CTRL_RST;
        else if (css_fire)
        begin
            // fallback beats a write in the same cycle: safety first
            ctrl_q.sys_src     <= rcb_pkg::SRC_FAST_INT;
            ctrl_q.ext_fast_en <= 1'b0;
            if (ctrl_q.pll_src_ext)
                ctrl_q.pll_en  <= 1'b0;
        end
        else if (wr && paddr == rcb_pkg::OFF_CLK_CTRL)
        begin
            ctrl_q <= rcb_pkg::clk_ctrl_t'(pwdata[11:0]);
            // codes above the table keep the old frequency
            if (pwdata[2:0] > rcb_pkg::FREQ_24M)
                ctrl_q.fast_freq <= ctrl_q.fast_freq;
        end
    end

    // divider shifts; apb shift is limited to its range
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            div_q <= rcb_pkg::CLK_DIV_RST;
        else if (wr && paddr == rcb_pkg::OFF_CLK_DIV)
        begin
            div_q.ahb_shift <= pwdata[2:0];
            div_q.apb_shift <= (pwdata[5:3] > rcb_pkg::APB_SHIFT_MAX)
                ? rcb_pkg::APB_SHIFT_MAX : pwdata[5:3];
        end
    end

    // rate of the running source, pll doubling its input
    always_comb
    begin
        case (cur_src)
            rcb_pkg::SRC_EXT_FAST: sys_khz = EXT_FAST_KHZ;
            rcb_pkg::SRC_PLL:      sys_khz = (ctrl_q.pll_src_ext
                ? EXT_FAST_KHZ : rcb_pkg::fast_khz(ctrl_q.fast_freq)) << 1;
            rcb_pkg::SRC_SLOW_INT: sys_khz = rcb_pkg::SLOW_KHZ;
            default:               sys_khz = rcb_pkg::fast_khz(
                ctrl_q.fast_freq);
        endcase
    end

    // raise the ahb shift until the bus rate fits; apb follows below it
    always_comb
    begin
        ahb_eff = div_q.ahb_shift;
        for (int s = 0; s < 8; s++)
            if ((sys_khz >> ahb_eff) > rcb_pkg::BUS_MAX_KHZ)
                ahb_eff = ahb_eff + 3'h1;
    end

    // low power control: sleep and stop requests, wake handling
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pwr_q   <= rcb_pkg::POWER_RST;
            stop_q  <= 1'b0;
            sleep_q <= 1'b0;
        end
        else
        begin
            if (wr && paddr == rcb_pkg::OFF_POWER)
                pwr_q <= rcb_pkg::power_t'(pwdata[10:0]);
            if (stop_q)
            begin
                if (|i_wake)
                    stop_q <= 1'b0;
            end
            else if (sleep_q)
            begin
                if (|i_wake || o_irq || o_nmi)
                    sleep_q <= 1'b0;
            end
            else if (wr && paddr == rcb_pkg::OFF_POWER)
            begin
                // stop wins when both are asked for at once
                stop_q  <= pwdata[1];
                sleep_q <= pwdata[0] && !pwdata[1];
            end
        end
    end

    // supply detector setup and its sampled output
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sup_q     <= rcb_pkg::SUPPLY_RST;
            sup_q_out <= 1'b0;
        end
        else
        begin
            if (wr && paddr == rcb_pkg::OFF_SUPPLY)
                sup_q <= rcb_pkg::supply_t'(pwdata[4:0]);
            sup_q_out <= sup_q.enable && i_supply_above;
        end
    end

    // events of this cycle
    always_comb
    begin
        ev_set             = '0;
        ev_set.css_fail    = css_fire;
        ev_set.supply_rise = sup_q.enable && i_supply_above && !sup_q_out;
        ev_set.supply_fall = sup_q_out && !i_supply_above;
        ev_set.stop_wake   = stop_q && |i_wake;
    end

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ev_q    <= '0;
            ev_en_q <= '0;
        end
        else
        begin
            if (wr && paddr == rcb_pkg::OFF_IRQ_EN)
                ev_en_q <= rcb_pkg::events_t'(pwdata[3:0]);
            if (wr && paddr == rcb_pkg::OFF_IRQ_CLR)
                ev_q <= (ev_q & ~rcb_pkg::events_t'(pwdata[3:0])) | ev_set;
            else
                ev_q <= ev_q | ev_set;
        end
    end

    // reset sources gathered; power reset feeds the system reset
    always_comb
    begin
        cause_set          = '0;
        cause_set.power    = i_por_low
            || (i_opt_bor_en && i_bor_low);
        cause_set.pin      = i_ext_reset_pin;
        cause_set.win_wdog = i_win_wdog_exp;
        cause_set.ind_wdog = i_ind_wdog_exp;
        cause_set.soft_req = i_soft_reset_req;
        cause_set.opt_load = i_opt_load_reset;
    end

    // reset outputs and cause flags; por path ignores every mode bit
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pwr_rst_q <= 1'b1;
            sys_rst_q <= 1'b1;
            cause_q   <= '0;
        end
        else
        begin
            pwr_rst_q <= cause_set.power;
            sys_rst_q <= |cause_set;
            if (wr && paddr == rcb_pkg::OFF_RST_CAUSE)
                cause_q <= cause_set;
            else
                cause_q <= cause_q | cause_set;
        end
    end

    // readiness of each source for the switch
    assign src_rdy = {i_slow_int_rdy, i_pll_lock, i_ext_fast_rdy,
        i_fast_rdy};

    // glitch-free source switch
    clk_switch_seq u_switch (
        .i_clk     (i_clk),
        .i_rstn    (i_rstn),
        .i_req_src (ctrl_q.sys_src),
        .i_ready   (src_rdy),
        .o_gate    (o_sys_gate),
        .o_cur_src (cur_src)
    );

    // register decode for reads
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            rcb_pkg::OFF_CLK_CTRL:  rd_mux[11:0] = ctrl_q;
            rcb_pkg::OFF_CLK_DIV:   rd_mux = {26'h0, div_q.apb_shift,
                ahb_eff};
            rcb_pkg::OFF_STATUS:    rd_mux[9:0] = {sleep_q, stop_q,
                sup_q_out, i_pll_lock, i_ext_fast_rdy, i_fast_rdy,
                cur_src, boot_q};
            rcb_pkg::OFF_POWER:     rd_mux[10:0] = pwr_q;
            rcb_pkg::OFF_SUPPLY:    rd_mux[4:0] = sup_q;
            rcb_pkg::OFF_IRQ_STAT:  rd_mux[3:0] = ev_q;
            rcb_pkg::OFF_IRQ_EN:    rd_mux[3:0] = ev_en_q;
            rcb_pkg::OFF_IRQ_CLR:   rd_mux = 32'h0000_0000;
            rcb_pkg::OFF_RST_CAUSE: rd_mux[5:0] = cause_q;
            default:                mapped = 1'b0;
        endcase
    end

    // read data and error caught in the setup cycle, shown in access
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !mapped;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;             // never waits: one access cycle
    assign pslverr = psel && penable && pslverr_q;

    // stop gates off the fast clocks and pll, enables stay stored
    assign o_fast_osc_en   = !stop_q;
    assign o_ext_fast_en   = ctrl_q.ext_fast_en && !stop_q;
    assign o_pll_en        = ctrl_q.pll_en && !stop_q;
    assign o_fast_osc_freq = ctrl_q.fast_freq;
    assign o_pll_src_ext   = ctrl_q.pll_src_ext;
    assign o_slow_int_en   = ctrl_q.slow_int_en;
    assign o_slow_ext_en   = ctrl_q.slow_ext_en;
    assign o_ahb_shift     = ahb_eff;
    assign o_apb_shift     = div_q.apb_shift;
    assign o_cpu_clk_en    = !sleep_q && !stop_q;
    // only peripherals marked to keep running see a clock in sleep
    assign o_periph_clk_en = stop_q ? 8'h00
        : (sleep_q ? pwr_q.keep_mask : 8'hff);
    assign o_stop_lp_reg   = stop_q && pwr_q.stop_lp_reg;
    assign o_boot_area     = boot_q;
    assign o_irq           = |(ev_q & ev_en_q);
    // nmi cannot be masked; it rises with the switch-over request
    assign o_nmi           = ev_q.css_fail;
    assign o_bor_en        = i_opt_bor_en;
    assign o_bor_rise_thr  = i_opt_bor_rise;
    assign o_bor_fall_thr  = i_opt_bor_fall;
    assign o_supply_level  = sup_q.level;
    assign o_supply_pin_sel = sup_q.pin_sel;
    assign o_supply_event  = sup_q_out;
    assign o_power_reset   = pwr_rst_q;
    assign o_system_reset  = sys_rst_q;
endmodule

// >>> tb/rcb_properties.sv
// port-level assertions for the reset, clock and boot block
`timescale 1ns/1ps
module rcb_properties (
    input wire logic       i_clk, i_rstn, psel, penable, pslverr,
    input wire logic       i_boot_select_pin, i_boot_option_bit,
    input wire logic       i_por_low, i_ext_reset_pin, o_nmi, o_pll_en,
    input wire logic       o_pll_src_ext, o_ext_fast_en, o_fast_osc_en,
    input wire logic       o_cpu_clk_en, o_power_reset, o_system_reset,
    input wire logic [1:0] o_boot_area,
    input wire logic [3:0] o_sys_gate,
    input wire logic [7:0] o_periph_clk_en,
    input wire logic [31:0] prdata
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // a running gate drops: start of a break-before-make switch
    sequence s_drop;
        o_sys_gate != 4'h0 ##1 o_sys_gate == 4'h0;
    endsequence
    a_boot_area:
        assert property ($rose(i_rstn) |=> o_boot_area == (i_boot_select_pin
            ? {!i_boot_option_bit, i_boot_option_bit} : 2'h0))
        else $error("boot area wrong");
    a_power_src:
        assert property (i_por_low |=> o_power_reset)
        else $error("power reset missing");
    a_system_src:
        assert property (i_ext_reset_pin || i_por_low |-> ##[1:2]
            o_system_reset) else $error("system reset missing");
    a_nmi_fallback:
        assert property ($rose(o_nmi) |-> !o_ext_fast_en &&
            !(o_pll_en && o_pll_src_ext) ##[1:12] o_sys_gate == 4'h1)
        else $error("no fallback with nmi");
    a_gate_onehot:
        assert property ($onehot0(o_sys_gate)) else $error("two gates on");
    a_gate_gap:
        assert property (s_drop |-> (o_sys_gate == 4'h0) [*4])
        else $error("switch gap too short");
    a_stop_gating:
        assert property (!o_fast_osc_en |-> !o_cpu_clk_en && !o_pll_en &&
            !o_ext_fast_en && o_periph_clk_en == 8'h00)
        else $error("clocks run in stop");
    a_err_access:
        assert property (pslverr |-> psel && penable && prdata == 32'h0)
        else $error("error outside access");
endmodule

// >>> tb/rcb_osc_model.sv
// oscillator and pll stand-ins: ready one cycle after enable
`timescale 1ns/1ps
module rcb_osc_model (
    input  wire logic       i_clk,
    input  wire logic [3:0] i_en,
    output logic [3:0]      o_rdy
);
    // ready drops one cycle after enable drops, no kinder than a real start-up
    always_ff @(posedge i_clk)
    begin
        o_rdy <= i_en;
    end
endmodule

// >>> tb/rst_clk_boot_ctrl_bench.sv
// self-checking bench for the reset, clock and boot block
`timescale 1ns/1ps
module rst_clk_boot_ctrl_bench;
    logic i_clk = 0, i_rstn = 0, psel = 0, penable = 0, pwrite = 0, perr;
    logic [7:0] paddr = 8'h00;
    logic i_opt_bor_en = 0, i_bor_low = 0, i_por_low = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [4:0] i_wake = 0, rsrc = 0;
    logic i_boot_select_pin = 0, i_boot_option_bit = 0, i_ext_fast_fail = 0;
    logic i_supply_above = 1, pready, pslverr, o_irq, o_nmi, o_bor_en;
    logic [2:0] i_opt_bor_rise = 3'h2, i_opt_bor_fall = 3'h1;
    logic [2:0] o_fast_osc_freq, o_ahb_shift, o_apb_shift, o_bor_rise_thr;
    logic [2:0] o_bor_fall_thr, o_supply_level;
    logic [1:0] o_boot_area;
    logic [3:0] o_sys_gate;
    logic [7:0] o_periph_clk_en;
    logic o_fast_osc_en, o_ext_fast_en, o_pll_en, o_pll_src_ext, o_cpu_clk_en;
    logic o_slow_int_en, o_slow_ext_en, o_stop_lp_reg, o_supply_pin_sel;
    logic o_supply_event, o_power_reset, o_system_reset;
    wire i_fast_rdy, i_ext_fast_rdy, i_pll_lock, i_slow_int_rdy;
    wire i_ext_reset_pin, i_win_wdog_exp, i_ind_wdog_exp, i_soft_reset_req;
    wire i_opt_load_reset;
    int err_total = 0, n_checks = 0, k, n;
    assign {i_opt_load_reset, i_soft_reset_req, i_ind_wdog_exp,
        i_win_wdog_exp, i_ext_reset_pin} = rsrc;
    always #2.5 i_clk = ~i_clk;
    rst_clk_boot_ctrl dut (.*);
    rcb_osc_model far (.i_clk(i_clk), .i_en({o_slow_int_en, o_pll_en,
        o_ext_fast_en, o_fast_osc_en}), .o_rdy({i_slow_int_rdy, i_pll_lock,
        i_ext_fast_rdy, i_fast_rdy}));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // a wait that ran out ends the run
    task automatic tmo();
        if (n > 40)
        begin
            chk(0, 1);
            finish_test();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1;
        n = 0;
        do @(posedge i_clk); while (pready !== 1 && n++ < 40);
        tmo();
        rd = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge i_clk);
    endtask
    initial
    begin
        for (k = 0; k < 3; k++)
        begin
            {i_boot_select_pin, i_boot_option_bit} <= {k != 0, k == 1};
            i_rstn <= 0;
            repeat (4) @(posedge i_clk);
            i_rstn <= 1;
            repeat (2) @(posedge i_clk);
            chk(o_boot_area, k);
        end
        $display("boot areas done");
        apb(0, rcb_pkg::OFF_CLK_CTRL, 0);
        chk({rd, o_sys_gate}, {32'h1, 4'h1});
        for (k = 5; k >= 0; k--)
        begin
            apb(1, rcb_pkg::OFF_CLK_CTRL, k);
            chk(o_fast_osc_freq, (k == 5) ? 1 : k);
        end
        apb(0, 8'h24, 0);
        chk({perr, rd}, 33'h100000000);
        $display("clock setup done");
        apb(1, rcb_pkg::OFF_IRQ_EN, 1);
        apb(1, rcb_pkg::OFF_CLK_CTRL, 32'h179);
        n = 0;
        while (o_sys_gate !== 4'h4 && n++ < 40) @(posedge i_clk);
        tmo();
        i_ext_fast_fail <= 1;
        n = 0;
        while (o_sys_gate !== 4'h1 && n++ < 40) @(posedge i_clk);
        tmo();
        chk({o_nmi, o_irq, o_pll_en, o_ext_fast_en}, 4'hc);
        i_ext_fast_fail <= 0;
        apb(1, rcb_pkg::OFF_IRQ_EN, 0);
        chk({o_nmi, o_irq}, 2'h2);
        apb(1, rcb_pkg::OFF_IRQ_CLR, 1);
        chk({o_nmi, o_irq}, 2'h0);
        $display("fallback done");
        for (k = 0; k < 5; k++)
        begin
            apb(1, rcb_pkg::OFF_POWER, 32'h6);
            chk({o_fast_osc_en, o_cpu_clk_en, o_stop_lp_reg}, 1);
            i_wake <= 5'h1 << k;
            n = 0;
            while (o_fast_osc_en !== 1 && n++ < 40) @(posedge i_clk);
            tmo();
            i_wake <= 0;
        end
        apb(1, rcb_pkg::OFF_POWER, 32'h529);
        chk({o_cpu_clk_en, o_periph_clk_en}, 9'h0a5);
        $display("low power done");
        for (k = 0; k < 8; k++)
        begin
            {i_opt_bor_en, i_bor_low, i_por_low, rsrc} <= (k == 7) ? 8'h40 :
                (k == 6) ? 8'hc0 : 8'h1 << k;
            repeat (3) @(posedge i_clk);
            chk({o_bor_en, o_power_reset, o_system_reset},
                {k == 6, k inside {5, 6}, k < 7});
            {i_opt_bor_en, i_bor_low, i_por_low, rsrc} <= 0;
            repeat (3) @(posedge i_clk);
        end
        chk({o_bor_rise_thr, o_bor_fall_thr}, 6'h11);
        apb(0, rcb_pkg::OFF_RST_CAUSE, 0);
        chk(rd, 32'h3f);
        apb(1, rcb_pkg::OFF_CLK_DIV, 32'h3f);
        apb(0, rcb_pkg::OFF_CLK_DIV, 0);
        chk({rd, o_apb_shift}, {32'h27, 3'h4});
        apb(1, rcb_pkg::OFF_SUPPLY, 1);
        @(posedge i_clk);
        chk(o_supply_event, 1);
        i_supply_above <= 0;
        repeat (2) @(posedge i_clk);
        chk(o_supply_event, 0);
        $display("reset sources done");
        finish_test();
    end
endmodule
bind rst_clk_boot_ctrl rcb_properties u_props (.*);
